// *** src/cmpc_pkg.sv ***
// Shared constants and types for the two-comparator control and status block.
package cmpc_pkg;

  // Clock and instruction-cycle timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int INSTR_CYCLE_NS = 100;
  localparam int INSTR_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

  // Register indices on the 3-bit address port.
  localparam logic [2:0] OFS_CMP1_A = 3'h0;
  localparam logic [2:0] OFS_CMP1_B = 3'h1;
  localparam logic [2:0] OFS_CMP2_A = 3'h2;
  localparam logic [2:0] OFS_CMP2_B = 3'h3;
  localparam logic [2:0] OFS_MIRROR = 3'h4;
  localparam logic [2:0] OFS_FLAG = 3'h5;
  localparam logic [2:0] OFS_PORT = 3'h6;

  // Field positions in control register a.
  localparam int CA_EN_BIT = 7;
  localparam int CA_RES_BIT = 6;
  localparam int CA_INV_BIT = 4;
  localparam int CA_SPD_BIT = 2;
  localparam int CA_HYS_BIT = 1;
  localparam int CA_SYN_BIT = 0;

  // Field positions in control register b.
  localparam int CB_RISE_BIT = 7;
  localparam int CB_FALL_BIT = 6;
  localparam int CB_POS_LSB = 4;
  localparam int CB_NEG_LSB = 0;

  // Positive input select codes, equal to their route index.
  localparam logic [1:0] POS_PIN = 2'h0;
  localparam logic [1:0] POS_DAC = 2'h1;
  localparam logic [1:0] POS_FVR = 2'h2;
  localparam logic [1:0] POS_ANALOG_GROUND = 2'h3;

  // Negative input select codes; 4 and 5 are reserved.
  localparam logic [2:0] NEG_PIN3 = 3'h3;
  localparam logic [2:0] NEG_FVR = 3'h6;
  localparam logic [2:0] NEG_ANALOG_GROUND = 3'h7;
  localparam logic [2:0] OPAMP_SHARED_SEL = 3'h2;

  // Negative route indices beyond the four pins.
  localparam int NR_FVR = 4;
  localparam int NR_ANALOG_GROUND = 5;
  localparam int NR_OPAMP = 6;

  typedef struct packed {
    logic enable;
    logic invert;
    logic speed;
    logic hyst;
    logic sync_en;
  } cmpc_ctrl_a_t;

  typedef struct packed {
    logic rise_en;
    logic fall_en;
    logic [1:0] pos_sel;
    logic [2:0] neg_sel;
  } cmpc_ctrl_b_t;

  typedef struct packed {
    logic enable;
    logic speed;
    logic hyst;
    logic [3:0] pos_route;
    logic [6:0] neg_route;
  } cmpc_analog_t;

  localparam cmpc_ctrl_a_t CTRL_A_RST = '{enable: 1'b0, invert: 1'b0, speed: 1'b1,
                                          hyst: 1'b0, sync_en: 1'b0};
  localparam cmpc_ctrl_b_t CTRL_B_RST = '0;

endpackage

// *** src/cmpc_channel.sv ***
// One comparator's digital output path: synchroniser, polarity, latch, edges.
`timescale 1ns/1ps
module cmpc_channel (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Analog result and controls
  input wire logic i_raw,
  input wire logic i_enable,
  input wire logic i_invert,
  input wire logic i_sync_en,
  // Timing strobes
  input wire logic i_gate_fall,
  input wire logic i_latch_stb,
  // Results
  output logic o_status,
  output logic o_ext,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic status;
    logic ext;
    logic rise;
    logic fall;
  } cmpc_chan_st_t;

  cmpc_chan_st_t s_reg;
  cmpc_chan_st_t s_next;
  logic out_val;

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = i_raw; // [R20]
    s_next.sync2 = s_reg.sync1; // [R20]
    // A disabled core reads as low, so toggling enable or polarity still moves the output.
    out_val = (i_enable & s_reg.sync2) ^ i_invert; // [R5] [R6] [R18]
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    if (i_latch_stb) begin
      s_next.status = out_val; // [R19]
      s_next.rise = out_val & ~s_reg.status;
      s_next.fall = ~out_val & s_reg.status;
    end
    if (!i_sync_en || i_gate_fall) begin
      s_next.ext = out_val; // [R9]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_status = s_reg.status;
  assign o_ext = s_reg.ext;
  assign o_rise = s_reg.rise;
  assign o_fall = s_reg.fall;

  property p_status_value;
    @(posedge i_clk) disable iff (i_rst)
    i_latch_stb |=> o_status == ($past(s_reg.sync2 & i_enable) ^ $past(i_invert));
  endproperty
  a_status_value: assert property (p_status_value) else $error("status not polarity result"); // [R6]

  property p_status_hold;
    @(posedge i_clk) disable iff (i_rst)
    !i_latch_stb |=> $stable(o_status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved between latches"); // [R19]

  property p_sync_depth;
    @(posedge i_clk) disable iff (i_rst)
    i_raw ##1 i_raw |=> s_reg.sync2;
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong"); // [R20]

  property p_ext_hold;
    @(posedge i_clk) disable iff (i_rst)
    (i_sync_en && !i_gate_fall) |=> $stable(o_ext);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("synced output moved"); // [R9]

  property p_edge_seen;
    @(posedge i_clk) disable iff (i_rst)
    (i_latch_stb && (o_status != out_val)) |=> (o_rise ^ o_fall);
  endproperty
  a_edge_seen: assert property (p_edge_seen) else $error("status change gave no edge"); // [R18]

endmodule

// *** src/cmpc_top.sv ***
// Register bank and control logic for two analog comparators.
// Behaviour
// [R1] Positive select: 00 pin, 01 DAC, 10 fixed reference, 11 analog ground.
// [R2] Negative select: 000-011 pins 0-3, 100/101 nothing, 110 reference, 111 ground.
// [R3] A disabled comparator has every input disconnected.
// [R4] Control a bit 7 enables the comparator; resets to zero.
// [R5] Control a bit 6 reads the comparator result after polarity.
// [R6] Control a bit 4 inverts the result for status, edges and outputs.
// [R7] Control a bit 2 selects high speed when set; resets to one.
// [R8] Control a bit 1 enables input hysteresis.
// [R9] Control a bit 0 makes the timer output update on gate clock falls.
// [R10] Control b bit 7 sets the flag on a rising status edge.
// [R11] Control b bit 6 sets the flag on a falling status edge.
// [R12] Mirror register: bit 1 comparator two, bit 0 comparator one, others zero.
// [R13] Unused bits of the control registers read zero and ignore writes.
// [R14] Shared pin with the op-amp enabled routes the op-amp to the negative node.
// [R15] Port reads give zero for every analog-selected pin.
// [R16] Software sets analog select and direction before using a pin.
// [R17] Software clears the flag; an edge in the clearing cycle keeps it set.
// [R18] Toggling polarity or enable can raise an edge and the flag.
// [R19] Status is latched once per instruction cycle.
// [R20] Raw results pass a two-stage synchroniser before use.
`timescale 1ns/1ps
module cmpc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Comparator cores and neighbours
  input wire logic [1:0] i_raw,
  input wire logic i_gate_clk,
  input wire logic [1:0] i_opamp_en,
  // Port pins
  input wire logic [7:0] i_pin_level,
  input wire logic [7:0] i_analog_sel,
  // Analog controls, timer outputs and flags
  output cmpc_pkg::cmpc_analog_t [1:0] o_analog,
  output logic [1:0] o_gate_out,
  output logic [1:0] o_irq_flag
);

  typedef struct packed {
    cmpc_pkg::cmpc_ctrl_a_t [1:0] ctrl_a;
    cmpc_pkg::cmpc_ctrl_b_t [1:0] ctrl_b;
    logic [1:0] flag;
    logic [7:0] rdata;
    cmpc_pkg::cmpc_analog_t [1:0] analog;
    logic gate_prev;
    logic gate_fall;
    logic [1:0] icnt;
    logic latch_stb;
  } cmpc_top_st_t;

  cmpc_top_st_t s_reg;
  cmpc_top_st_t s_next;
  logic [1:0] status;
  logic [1:0] rise;
  logic [1:0] fall;

  function automatic cmpc_pkg::cmpc_ctrl_a_t wr_ctrl_a(input logic [7:0] d);
    cmpc_pkg::cmpc_ctrl_a_t c;
    c.enable = d[cmpc_pkg::CA_EN_BIT];
    c.invert = d[cmpc_pkg::CA_INV_BIT];
    c.speed = d[cmpc_pkg::CA_SPD_BIT];
    c.hyst = d[cmpc_pkg::CA_HYS_BIT];
    c.sync_en = d[cmpc_pkg::CA_SYN_BIT];
    return c;
  endfunction

  function automatic logic [7:0] rd_ctrl_a(input cmpc_pkg::cmpc_ctrl_a_t c, input logic st);
    logic [7:0] r;
    r = 8'h00; // [R13]
    r[cmpc_pkg::CA_EN_BIT] = c.enable;
    r[cmpc_pkg::CA_RES_BIT] = st; // [R5]
    r[cmpc_pkg::CA_INV_BIT] = c.invert;
    r[cmpc_pkg::CA_SPD_BIT] = c.speed;
    r[cmpc_pkg::CA_HYS_BIT] = c.hyst;
    r[cmpc_pkg::CA_SYN_BIT] = c.sync_en;
    return r;
  endfunction

  function automatic cmpc_pkg::cmpc_ctrl_b_t wr_ctrl_b(input logic [7:0] d);
    cmpc_pkg::cmpc_ctrl_b_t c;
    c.rise_en = d[cmpc_pkg::CB_RISE_BIT];
    c.fall_en = d[cmpc_pkg::CB_FALL_BIT];
    c.pos_sel = d[cmpc_pkg::CB_POS_LSB +: 2];
    c.neg_sel = d[cmpc_pkg::CB_NEG_LSB +: 3];
    return c;
  endfunction

  function automatic logic [7:0] rd_ctrl_b(input cmpc_pkg::cmpc_ctrl_b_t c);
    logic [7:0] r;
    r = 8'h00; // [R13]
    r[cmpc_pkg::CB_RISE_BIT] = c.rise_en;
    r[cmpc_pkg::CB_FALL_BIT] = c.fall_en;
    r[cmpc_pkg::CB_POS_LSB +: 2] = c.pos_sel;
    r[cmpc_pkg::CB_NEG_LSB +: 3] = c.neg_sel;
    return r;
  endfunction

  function automatic logic [3:0] pos_route(input logic en, input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h0;
    if (en) begin // [R3]
      case (sel)
        cmpc_pkg::POS_PIN: r[cmpc_pkg::POS_PIN] = 1'b1; // [R1]
        cmpc_pkg::POS_DAC: r[cmpc_pkg::POS_DAC] = 1'b1;
        cmpc_pkg::POS_FVR: r[cmpc_pkg::POS_FVR] = 1'b1;
        default: r[cmpc_pkg::POS_ANALOG_GROUND] = 1'b1;
      endcase
    end
    return r;
  endfunction

  function automatic logic [6:0] neg_route(input logic en, input logic [2:0] sel,
                                           input logic opamp);
    logic [6:0] r;
    r = 7'h00;
    if (en) begin // [R3]
      if (sel <= cmpc_pkg::NEG_PIN3) begin
        if (sel == cmpc_pkg::OPAMP_SHARED_SEL && opamp) begin
          r[cmpc_pkg::NR_OPAMP] = 1'b1; // [R14]
        end else begin
          r[sel[1:0]] = 1'b1; // [R2]
        end
      end else if (sel == cmpc_pkg::NEG_FVR) begin
        r[cmpc_pkg::NR_FVR] = 1'b1; // [R2]
      end else if (sel == cmpc_pkg::NEG_ANALOG_GROUND) begin
        r[cmpc_pkg::NR_ANALOG_GROUND] = 1'b1; // [R2]
      end
    end
    return r;
  endfunction

  // Both comparator channels share the instruction strobe and the gate clock edge.
  for (genvar k = 0; k < 2; k++) begin : g_chan
    cmpc_channel u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_raw(i_raw[k]),
      .i_enable(s_reg.ctrl_a[k].enable),
      .i_invert(s_reg.ctrl_a[k].invert),
      .i_sync_en(s_reg.ctrl_a[k].sync_en),
      .i_gate_fall(s_reg.gate_fall),
      .i_latch_stb(s_reg.latch_stb),
      .o_status(status[k]),
      .o_ext(o_gate_out[k]),
      .o_rise(rise[k]),
      .o_fall(fall[k])
    );
  end

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    // The gate clock is sampled as a plain input; its falls pace synced outputs.
    s_next.gate_prev = i_gate_clk;
    s_next.gate_fall = s_reg.gate_prev & ~i_gate_clk; // [R9]
    s_next.latch_stb = (s_reg.icnt == cmpc_pkg::INSTR_LAST); // [R19]
    if (s_reg.icnt == cmpc_pkg::INSTR_LAST) begin
      s_next.icnt = 2'h0;
    end else begin
      s_next.icnt = s_reg.icnt + 2'h1;
    end
    if (i_wr) begin
      case (i_addr)
        cmpc_pkg::OFS_CMP1_A: s_next.ctrl_a[0] = wr_ctrl_a(i_wdata); // [R4] [R7] [R8]
        cmpc_pkg::OFS_CMP1_B: s_next.ctrl_b[0] = wr_ctrl_b(i_wdata);
        cmpc_pkg::OFS_CMP2_A: s_next.ctrl_a[1] = wr_ctrl_a(i_wdata);
        cmpc_pkg::OFS_CMP2_B: s_next.ctrl_b[1] = wr_ctrl_b(i_wdata);
        default: s_next.ctrl_a = s_reg.ctrl_a;
      endcase
    end
    for (int k = 0; k < 2; k++) begin
      // Writing zero to a flag bit clears it, but a fresh edge in that cycle wins.
      if (i_wr && i_addr == cmpc_pkg::OFS_FLAG && !i_wdata[k]) begin
        s_next.flag[k] = 1'b0; // [R17]
      end
      if ((rise[k] && s_reg.ctrl_b[k].rise_en) || (fall[k] && s_reg.ctrl_b[k].fall_en)) begin
        s_next.flag[k] = 1'b1; // [R10] [R11] [R17]
      end
      s_next.analog[k].enable = s_reg.ctrl_a[k].enable; // [R4]
      s_next.analog[k].speed = s_reg.ctrl_a[k].speed; // [R7]
      s_next.analog[k].hyst = s_reg.ctrl_a[k].hyst; // [R8]
      s_next.analog[k].pos_route = pos_route(s_reg.ctrl_a[k].enable, s_reg.ctrl_b[k].pos_sel);
      s_next.analog[k].neg_route = neg_route(s_reg.ctrl_a[k].enable,
                                             s_reg.ctrl_b[k].neg_sel, i_opamp_en[k]);
    end
    if (i_rd) begin
      case (i_addr)
        cmpc_pkg::OFS_CMP1_A: s_next.rdata = rd_ctrl_a(s_reg.ctrl_a[0], status[0]);
        cmpc_pkg::OFS_CMP1_B: s_next.rdata = rd_ctrl_b(s_reg.ctrl_b[0]);
        cmpc_pkg::OFS_CMP2_A: s_next.rdata = rd_ctrl_a(s_reg.ctrl_a[1], status[1]);
        cmpc_pkg::OFS_CMP2_B: s_next.rdata = rd_ctrl_b(s_reg.ctrl_b[1]);
        cmpc_pkg::OFS_MIRROR: s_next.rdata = {6'h00, status}; // [R12]
        cmpc_pkg::OFS_FLAG: s_next.rdata = {6'h00, s_reg.flag};
        cmpc_pkg::OFS_PORT: s_next.rdata = i_pin_level & ~i_analog_sel; // [R15]
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.ctrl_a <= {cmpc_pkg::CTRL_A_RST, cmpc_pkg::CTRL_A_RST}; // [R7]
      s_reg.ctrl_b <= {cmpc_pkg::CTRL_B_RST, cmpc_pkg::CTRL_B_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_analog = s_reg.analog;
  assign o_irq_flag = s_reg.flag;

  property p_rise_sets_flag;
    @(posedge i_clk) disable iff (i_rst)
    (rise[0] && s_reg.ctrl_b[0].rise_en) |=> o_irq_flag[0];
  endproperty
  a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("rise lost"); // [R10]

  property p_fall_sets_flag;
    @(posedge i_clk) disable iff (i_rst)
    (fall[1] && s_reg.ctrl_b[1].fall_en) |=> o_irq_flag[1];
  endproperty
  a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("fall lost"); // [R11]

  property p_clear_flag;
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == cmpc_pkg::OFS_FLAG && !i_wdata[0] && !rise[0] && !fall[0])
      |=> !o_irq_flag[0];
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("flag not cleared"); // [R17]

  property p_disabled_routes;
    @(posedge i_clk) disable iff (i_rst)
    !s_reg.ctrl_a[0].enable |=> (o_analog[0].pos_route == 4'h0)
                                && (o_analog[0].neg_route == 7'h00);
  endproperty
  a_disabled_routes: assert property (p_disabled_routes) else $error("input left on"); // [R3]

  property p_pos_analog_ground;
    @(posedge i_clk) disable iff (i_rst)
    (s_reg.ctrl_a[1].enable && s_reg.ctrl_b[1].pos_sel == cmpc_pkg::POS_ANALOG_GROUND)
      |=> o_analog[1].pos_route == 4'h8;
  endproperty
  a_pos_analog_ground: assert property (p_pos_analog_ground) else $error("ground not routed"); // [R1]

  property p_neg_reserved;
    @(posedge i_clk) disable iff (i_rst)
    (s_reg.ctrl_b[0].neg_sel[2:1] == 2'h2) |=> o_analog[0].neg_route == 7'h00;
  endproperty
  a_neg_reserved: assert property (p_neg_reserved) else $error("reserved code routed"); // [R2]

  property p_opamp_route;
    @(posedge i_clk) disable iff (i_rst)
    (s_reg.ctrl_a[0].enable && i_opamp_en[0]
     && s_reg.ctrl_b[0].neg_sel == cmpc_pkg::OPAMP_SHARED_SEL) |=> o_analog[0].neg_route == 7'h40;
  endproperty
  a_opamp_route: assert property (p_opamp_route) else $error("op-amp not routed"); // [R14]

  property p_port_analog_zero;
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == cmpc_pkg::OFS_PORT) |=> (o_rdata & $past(i_analog_sel)) == 8'h00;
  endproperty
  a_port_analog_zero: assert property (p_port_analog_zero) else $error("analog pin read"); // [R15]

  property p_mirror;
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == cmpc_pkg::OFS_MIRROR) |=> o_rdata == {6'h00, $past(status)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror mismatch"); // [R12]

  property p_strobe_spacing;
    @(posedge i_clk) disable iff (i_rst)
    s_reg.latch_stb |=> !s_reg.latch_stb [*3] ##1 s_reg.latch_stb;
  endproperty
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("latch pace wrong"); // [R19]

  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read"); // [R13]

endmodule

// *** dv/cmpc_partner.sv ***
// Behavioural model of the two analog comparator cores and the gate timer clock.
`timescale 1ns/1ps
module cmpc_partner (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Controls from the block and wanted node relation
  input wire cmpc_pkg::cmpc_analog_t [1:0] i_analog,
  input wire logic [1:0] i_above,
  input wire logic i_gate_run,
  // Core results and gate clock
  output logic [1:0] o_raw,
  output logic o_gate_clk
);
  logic [1:0] d1_reg;
  logic [1:0] d2_reg;
  logic [1:0] d3_reg;
  logic tog_reg;
  logic [1:0] gcnt_reg;

  // A dead or unrouted core gives garbage, so the block must not trust it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      d1_reg <= 2'h0;
      d2_reg <= 2'h0;
      d3_reg <= 2'h0;
      tog_reg <= 1'b0;
      o_raw <= 2'h0;
      gcnt_reg <= 2'h0;
      o_gate_clk <= 1'b1;
    end else begin
      d1_reg <= i_above;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
      tog_reg <= ~tog_reg;
      for (int k = 0; k < 2; k++) begin
        if (!(i_analog[k].enable && |i_analog[k].pos_route && |i_analog[k].neg_route)) begin
          o_raw[k] <= tog_reg ^ k[0];
        end else begin
          o_raw[k] <= i_analog[k].speed ? d1_reg[k] : d3_reg[k];
        end
      end
      // The gate clock stands high whenever the timer is stopped.
      if (!i_gate_run) begin
        gcnt_reg <= 2'h0;
        o_gate_clk <= 1'b1;
      end else if (gcnt_reg == 2'h2) begin
        gcnt_reg <= 2'h0;
        o_gate_clk <= ~o_gate_clk;
      end else begin
        gcnt_reg <= gcnt_reg + 2'h1;
      end
    end
  end
endmodule

// *** dv/comparator_control_logic_tb_top.sv ***
// Self-checking testbench for the two-comparator control and status block.
`timescale 1ns/1ps
module comparator_control_logic_tb_top;
  logic i_clk;
  logic i_rst;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] o_rdata;
  logic [1:0] raw;
  logic gate_clk;
  logic [1:0] i_opamp_en;
  logic [7:0] i_pin_level;
  logic [7:0] i_analog_sel;
  cmpc_pkg::cmpc_analog_t [1:0] ana;
  logic [1:0] o_gate_out;
  logic [1:0] o_irq_flag;
  logic [1:0] above;
  logic gate_run;
  int bad_count;
  int compares;

  cmpc_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_raw(raw), .i_gate_clk(gate_clk),
    .i_opamp_en(i_opamp_en), .i_pin_level(i_pin_level), .i_analog_sel(i_analog_sel),
    .o_analog(ana), .o_gate_out(o_gate_out), .o_irq_flag(o_irq_flag));

  cmpc_partner core_u (.i_clk(i_clk), .i_rst(i_rst), .i_analog(ana), .i_above(above),
    .i_gate_run(gate_run), .o_raw(raw), .o_gate_clk(gate_clk));

  always #12.5 i_clk = ~i_clk;

  task automatic conclude();
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk($sformatf("rdata at %0d", a), exp, o_rdata);
  endtask

  task automatic t_reset();
    rd(3'h0, 8'h04);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h04);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    chk("speed", 8'h01, {7'h0, ana[0].speed});
  endtask

  task automatic t_ctrl();
    wr(3'h0, 8'hae);
    // A freshly enabled core is unsettled for a few cycles, so let status settle first.
    cyc(12);
    rd(3'h0, 8'h86);
    chk("hyst", 8'h01, {7'h0, ana[0].hyst});
    wr(3'h1, 8'hff);
    rd(3'h1, 8'hf7);
    wr(3'h4, 8'hff);
    rd(3'h4, 8'h00);
  endtask

  task automatic t_route();
    logic [6:0] nx;
    wr(3'h0, 8'h84);
    for (int p = 0; p < 4; p++) begin
      for (int n = 0; n < 8; n++) begin
        wr(3'h1, {2'b00, 2'(p), 1'b0, 3'(n)});
        cyc(2);
        nx = (n < 4) ? 7'(1 << n) : (n == 6) ? 7'h10 : (n == 7) ? 7'h20 : 7'h00;
        chk("pos route", 8'(1 << p), {4'h0, ana[0].pos_route});
        chk("neg route", {1'b0, nx}, {1'b0, ana[0].neg_route});
      end
    end
    i_opamp_en <= 2'b01;
    wr(3'h1, 8'h02);
    cyc(2);
    chk("opamp route", 8'h40, {1'b0, ana[0].neg_route});
    i_opamp_en <= 2'b00;
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h00);
    cyc(2);
    chk("off routes", 8'h00, {ana[0].enable, ana[0].pos_route, ana[0].neg_route[2:0]});
    chk("off neg", 8'h00, {1'b0, ana[0].neg_route});
  endtask

  task automatic t_edges();
    wr(3'h1, 8'h80);
    wr(3'h0, 8'h84);
    cyc(12);
    wr(3'h5, 8'h00);
    above <= 2'b01;
    cyc(16);
    rd(3'h0, 8'hc4);
    rd(3'h4, 8'h01);
    rd(3'h5, 8'h01);
    wr(3'h5, 8'h00);
    rd(3'h5, 8'h00);
    above <= 2'b00;
    cyc(16);
    rd(3'h5, 8'h00);
    wr(3'h0, 8'h94);
    cyc(12);
    rd(3'h0, 8'hd4);
    rd(3'h5, 8'h01);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h84);
    cyc(12);
    rd(3'h5, 8'h01);
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h10);
    cyc(12);
    rd(3'h5, 8'h00);
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'h00);
    cyc(12);
    rd(3'h5, 8'h01);
    rd(3'h0, 8'h00);
    wr(3'h2, 8'h84);
    above <= 2'b10;
    cyc(16);
    rd(3'h4, 8'h02);
    rd(3'h2, 8'hc4);
    chk("gate out two", 8'h01, {7'h0, o_gate_out[1]});
    wr(3'h3, 8'h70);
    cyc(2);
    chk("pos route two", 8'h08, {4'h0, ana[1].pos_route});
    wr(3'h2, 8'h04);
    above <= 2'b00;
    cyc(12);
    rd(3'h5, 8'h03);
    chk("irq flags", 8'h03, {6'h00, o_irq_flag});
  endtask

  task automatic t_sync();
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h84);
    cyc(16);
    chk("gate out", 8'h00, {7'h0, o_gate_out[0]});
    above <= 2'b01;
    cyc(16);
    chk("gate out", 8'h01, {7'h0, o_gate_out[0]});
    wr(3'h0, 8'h85);
    above <= 2'b00;
    cyc(20);
    chk("gate held", 8'h01, {7'h0, o_gate_out[0]});
    rd(3'h0, 8'h85);
    gate_run <= 1'b1;
    cyc(20);
    chk("gate synced", 8'h00, {7'h0, o_gate_out[0]});
    gate_run <= 1'b0;
    wr(3'h0, 8'h80);
    above <= 2'b01;
    cyc(20);
    rd(3'h0, 8'hc0);
    chk("low speed", 8'h00, {7'h0, ana[0].speed});
  endtask

  task automatic t_port();
    // Software marks analog pins before use, so the port view must hide them.
    i_pin_level <= 8'hff;
    i_analog_sel <= 8'h0f;
    rd(3'h6, 8'hf0);
    i_analog_sel <= 8'ha5;
    rd(3'h6, 8'h5a);
  endtask

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_opamp_en = 2'h0;
    i_pin_level = 8'h00;
    i_analog_sel = 8'h00;
    above = 2'h0;
    gate_run = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_route();
    t_edges();
    t_sync();
    t_port();
    conclude();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge i_clk);
    bad_count++;
    conclude();
  end
endmodule
